// ==== bench/irq_host_model.sv ====
`timescale 1ns/1ps
module irq_host_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // from bench and device
  input wire logic ack_req,
  input wire logic nmi_out,
  // to device and bench
  output logic interrupt_acknowledge_strobe_n,
  output int nmi_edges
);
  logic nmi_ff;
  initial interrupt_acknowledge_strobe_n = 1'b1;
  // two low strobes per answer, each held across two clock edges
  always
  begin
    @(posedge clk_sys);
    if (ack_req)
    begin
      repeat (2)
      begin
        @(negedge clk_sys);
        interrupt_acknowledge_strobe_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        interrupt_acknowledge_strobe_n = 1'b1;
        @(negedge clk_sys);
      end
    end
  end
  // the processor only notices a rising nmi, never a held level
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      nmi_ff <= 1'b0;
      nmi_edges <= 0;
    end
    else
    begin
      nmi_ff <= nmi_out;
      if (nmi_out && !nmi_ff) nmi_edges <= nmi_edges + 1;
    end
  end
endmodule

// ==== bench/irq_nmi_sva.sv ====
`timescale 1ns/1ps
module irq_nmi_sva
  import irq_nmi_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // i/o port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  // error inputs and processor side
  input wire logic chan_chk_n,
  input wire logic interrupt_acknowledge_strobe_n,
  input wire logic [7:0] vector_out,
  input wire logic vector_valid,
  input wire logic nmi_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic rd_map;
  logic nmi_wr;
  assign rd_map = io_addr inside {PORT_NMI_STATUS, PORT_NMI_MASK,
    PORT_MASTER_CTRL, PORT_SLAVE_CTRL, PORT_MASTER_TRIG, PORT_SLAVE_TRIG};
  assign nmi_wr = io_wr && io_addr inside {PORT_NMI_MASK, PORT_NMI_STATUS};
  a_read_answer: assert property (io_rvalid == $past(io_rd))
    else $error("read answer not one cycle after strobe");
  a_unmapped_zero: assert property (io_rd && !rd_map |=>
    io_rdata == 8'h00) else $error("unmapped read not zero");
  a_status_clear: assert property (io_rd && io_addr == PORT_NMI_STATUS
    |=> !(io_rdata[6] && io_rdata[3]) && !(io_rdata[7] && io_rdata[2]))
    else $error("disabled source shows pending");
  // detector needs a settled enable, so recent writes leave it unchecked
  a_chk_latch: assert property (io_rd && io_addr == PORT_NMI_STATUS
    && $past(!chan_chk_n, 2) && !$past(io_wr) && !$past(io_wr, 2)
    |=> io_rdata[6] || io_rdata[3]) else $error("check cause not latched");
  a_mask_blocks: assert property (io_wr && io_addr == PORT_NMI_MASK
    && io_wdata[NMI_MASK_BIT] |-> ##2 !nmi_out)
    else $error("mask did not block nmi");
  a_disable_drops: assert property (io_wr && io_addr == PORT_NMI_STATUS
    && io_wdata[3:2] == 2'b11 |-> ##3 !nmi_out)
    else $error("disabled sources still give nmi");
  // a mask write drops nmi two edges later, a disable write three
  a_nmi_holds: assert property ($fell(nmi_out) |->
    $past(nmi_wr, 2) || $past(nmi_wr, 3))
    else $error("nmi dropped without a port write");
  a_vec_after_ack: assert property (vector_valid |->
    $past(!interrupt_acknowledge_strobe_n, 2))
    else $error("vector without acknowledge strobe");
  a_vector_base: assert property (vector_valid |->
    vector_out[7:3] inside {5'h01, 5'h0e}) else $error("vector base wrong");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t got %h exp %h", $time, a, b); end end
module testbench;
  import irq_nmi_pkg::*;
  logic clk_sys, rst, io_wr, io_rd, io_rvalid, sys_err_n, chan_chk_n;
  logic ack_n, intr_out, vector_valid, nmi_out, ack_req, intr_b;
  logic [15:0] io_addr, irq_in;
  logic [7:0] io_wdata, io_rdata, vector_out, v, e;
  logic [7:0] rq[$], vq[$];
  int fail_count, num_checks, cycles, nmi_edges, seed;
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  irq_nmi_logic #(.PER_LINE(1'b1)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .irq_in(irq_in),
    .sys_err_n(sys_err_n), .chan_chk_n(chan_chk_n),
    .interrupt_acknowledge_strobe_n(ack_n), .intr_out(intr_out),
    .vector_out(vector_out), .vector_valid(vector_valid),
    .nmi_out(nmi_out));
  // bank-select build shares every input, only its request line is watched
  irq_nmi_logic #(.PER_LINE(1'b0)) dut_bank_u (.clk_sys(clk_sys), .rst(rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(), .io_rvalid(), .irq_in(irq_in),
    .sys_err_n(sys_err_n), .chan_chk_n(chan_chk_n),
    .interrupt_acknowledge_strobe_n(ack_n), .intr_out(intr_b),
    .vector_out(), .vector_valid(), .nmi_out());
  irq_host_model host_u (.clk_sys(clk_sys), .rst(rst), .ack_req(ack_req),
    .nmi_out(nmi_out), .interrupt_acknowledge_strobe_n(ack_n),
    .nmi_edges(nmi_edges));
  // ******
  // result watcher: oldest note against each answer
  // ******
  always @(negedge clk_sys)
  begin
    // pop once: the compare macro reads its expected value twice
    if (io_rvalid === 1'b1)
    begin
      e = rq.size() ? rq.pop_front() : 8'hxx;
      `CHK(io_rdata, e)
    end
    if (vector_valid === 1'b1)
    begin
      e = vq.size() ? vq.pop_front() : 8'hxx;
      `CHK(vector_out, e)
    end
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(negedge clk_sys);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
  endtask
  task automatic ack(input logic [7:0] e);
    vq.push_back(e);
    @(negedge clk_sys);
    ack_req = 1'b1;
    @(negedge clk_sys);
    ack_req = 1'b0;
    for (int i = 0; i < 30 && vq.size() > 0; i++) @(negedge clk_sys);
  endtask
  task automatic wait_intr;
    for (int i = 0; i < 20 && intr_out !== 1'b1; i++) @(negedge clk_sys);
  endtask
  initial
  begin
    {io_addr, io_wr, io_rd, io_wdata, irq_in, ack_req} = '0;
    {sys_err_n, chan_chk_n, rst} = 3'b111;
    seed = $urandom(56355);
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    rd(PORT_NMI_STATUS, RST_NMI_CTRL);
    rd(PORT_MASTER_TRIG, RST_TRIG);
    rd(PORT_SLAVE_TRIG, RST_TRIG);
    rd(16'h0055, 8'h00);
    // bank level bit must have no effect in the per-line build
    wr(PORT_MASTER_CTRL, 8'h18);
    irq_in[3] = 1'b1;
    wait_intr();
    `CHK(intr_out, 1'b1)
    ack(8'h0b);
    rd(PORT_MASTER_CTRL, 8'h08);
    wr(PORT_MASTER_CTRL, 8'h20);
    repeat (8) @(negedge clk_sys);
    `CHK(intr_out, 1'b0)
    `CHK(intr_b, 1'b1)
    rd(PORT_MASTER_CTRL, 8'h00);
    irq_in[3] = 1'b0;
    @(negedge clk_sys);
    irq_in[5] = 1'b1;
    wait_intr();
    irq_in[5] = 1'b0;
    ack(8'h0f);
    rd(PORT_MASTER_CTRL, 8'h00);
    wr(PORT_MASTER_TRIG, 8'h10);
    wait_intr();
    `CHK(intr_out, 1'b1)
    ack(8'h0c);
    irq_in[4] = 1'b1;
    wr(PORT_MASTER_CTRL, 8'h20);
    repeat (8) @(negedge clk_sys);
    `CHK(intr_out, 1'b0)
    wr(PORT_NMI_MASK, 8'h00);
    wr(PORT_NMI_STATUS, 8'h00);
    chan_chk_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    `CHK(nmi_out, 1'b1)
    rd(PORT_NMI_STATUS, 8'h40);
    wr(PORT_NMI_MASK, 8'h80);
    sys_err_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK(nmi_out, 1'b0)
    rd(PORT_NMI_STATUS, 8'hc0);
    wr(PORT_NMI_MASK, 8'h00);
    repeat (3) @(negedge clk_sys);
    `CHK(nmi_edges, 2)
    wr(PORT_NMI_STATUS, 8'h08);
    rd(PORT_NMI_STATUS, 8'h88);
    `CHK(nmi_out, 1'b1)
    {chan_chk_n, sys_err_n} = 2'b11;
    wr(PORT_NMI_STATUS, 8'h0c);
    rd(PORT_NMI_STATUS, 8'h0c);
    `CHK(nmi_out, 1'b0)
    v = 8'($urandom) & 8'hf8;
    wr(PORT_MASTER_TRIG, v);
    rd(PORT_MASTER_TRIG, v);
    v = 8'($urandom) & 8'hde;
    wr(PORT_SLAVE_TRIG, v);
    rd(PORT_SLAVE_TRIG, v);
    repeat (3) @(negedge clk_sys);
    finish_test();
  end
endmodule
bind irq_nmi_logic irq_nmi_sva sva_u (.clk_sys(clk_sys), .rst(rst),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid), .chan_chk_n(chan_chk_n),
  .interrupt_acknowledge_strobe_n(interrupt_acknowledge_strobe_n),
  .vector_out(vector_out), .vector_valid(vector_valid),
  .nmi_out(nmi_out));

// ==== design/irq_nmi_logic.sv ====
`timescale 1ns/1ps
// Function
// - bank bit 3 sets whole-bank sense
// - bank bit 0: rising edge, steady high ignored
// - bank bit 1: high level requests
// - vanished request answers default line 7
// - default line 7 leaves in-service bit
// - two 8-bit per-line trigger registers
// - per-line variant ignores bank bit
// - per-line bit 0: rising edge only
// - per-line bit 1: low level requests
// - latch nmi on system error or check low
// - status bit 6 check, bit 7 error
// - disabled source enable clears its detector
// - mask bit 7 gates, keeps detectors
// - nmi stays while enabled cause latched
// - reset: edge sensing, normal end, cascade
module irq_nmi_logic
  import irq_nmi_pkg::*;
#(
  parameter bit PER_LINE = 1'b1
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // i/o port access
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // request inputs, master lines 7:0 and slave lines 15:8
  input wire logic [15:0] irq_in,
  // error inputs, active low
  input wire logic sys_err_n,
  input wire logic chan_chk_n,
  // processor side
  input wire logic interrupt_acknowledge_strobe_n,
  output logic intr_out,
  output logic [7:0] vector_out,
  output logic vector_valid,
  output logic nmi_out
);
  localparam logic [7:0] MASTER_VEC_BASE = 8'h08;
  localparam logic [7:0] SLAVE_VEC_BASE = 8'h70;
  localparam logic [2:0] CASCADE_LINE = 3'h2;

  logic [7:0] master_trig_ff;
  logic [7:0] slave_trig_ff;
  logic master_bank_trig_ff;
  logic slave_bank_trig_ff;
  logic [7:0] nmi_ctrl_ff;
  logic nmi_mask_ff;
  logic chk_det_ff;
  logic serr_det_ff;
  logic ack_n_prev_ff;
  ack_state_e ack_ff;
  ack_state_e nxt_ack;
  logic use_slave_ff;
  logic [7:0] io_rdata_ff;
  logic io_rvalid_ff;
  logic intr_ff;
  logic [7:0] vector_ff;
  logic vector_valid_ff;
  logic nmi_ff;
  logic ack_fall;
  logic ack_first;
  logic ack_second;
  logic m_req;
  logic s_req;
  logic [2:0] m_line;
  logic [2:0] s_line;
  logic m_dflt;
  logic s_dflt;
  logic [7:0] m_insvc;
  logic [7:0] s_insvc;
  logic m_end;
  logic s_end;
  logic [7:0] m_clr;
  logic [7:0] s_clr;
  logic wr_m_ctl;
  logic wr_s_ctl;
  logic nmi_nxt;

  // ************************************************************
  // port decode
  // ************************************************************
  assign wr_m_ctl = io_wr && io_addr == PORT_MASTER_CTRL;
  assign wr_s_ctl = io_wr && io_addr == PORT_SLAVE_CTRL;
  // nonspecific end command on the control port
  assign m_end = wr_m_ctl && !io_wdata[INIT_WORD_BIT] && io_wdata[END_BIT];
  assign s_end = wr_s_ctl && !io_wdata[INIT_WORD_BIT] && io_wdata[END_BIT];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      master_trig_ff <= RST_TRIG;
      slave_trig_ff <= RST_TRIG;
    end
    else if (PER_LINE)
    begin
      if (io_wr && io_addr == PORT_MASTER_TRIG)
        master_trig_ff <= io_wdata;
      if (io_wr && io_addr == PORT_SLAVE_TRIG)
        slave_trig_ff <= io_wdata;
    end
  end

  // the bank bit only counts when the first init word is written
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      master_bank_trig_ff <= RST_BANK_TRIG;
      slave_bank_trig_ff <= RST_BANK_TRIG;
    end
    else if (!PER_LINE)
    begin
      if (wr_m_ctl && io_wdata[INIT_WORD_BIT])
        master_bank_trig_ff <= io_wdata[BANK_TRIG_BIT];
      if (wr_s_ctl && io_wdata[INIT_WORD_BIT])
        slave_bank_trig_ff <= io_wdata[BANK_TRIG_BIT];
    end
  end

  // ************************************************************
  // acknowledge sequence: two strobes per answer
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_n_prev_ff <= 1'b1;
    else
      ack_n_prev_ff <= interrupt_acknowledge_strobe_n;
  end

  assign ack_fall = ack_n_prev_ff && !interrupt_acknowledge_strobe_n;

  always_comb
  begin
    nxt_ack = ack_ff;
    case (ack_ff)
      ACK_IDLE:
        if (ack_fall)
          nxt_ack = ACK_FIRST;
      ACK_FIRST:
        nxt_ack = ACK_GAP;
      ACK_GAP:
        if (ack_fall)
          nxt_ack = ACK_SECOND;
      ACK_SECOND:
        nxt_ack = ACK_IDLE;
      default:
        nxt_ack = ACK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ack_ff <= ACK_IDLE;
    else
      ack_ff <= nxt_ack;
  end

  // request state is sampled at the first falling strobe
  assign ack_first = ack_ff == ACK_IDLE && ack_fall;
  assign ack_second = ack_ff == ACK_SECOND;

  // slave serves when cascade line 2 is the lowest master line pending
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      use_slave_ff <= 1'b0;
    else if (ack_ff == ACK_FIRST)
      use_slave_ff <= !m_dflt && m_line == CASCADE_LINE;
  end

  assign m_clr = (ack_second && !use_slave_ff && !m_dflt)
               ? 8'(1 << m_line) : 8'h00;
  assign s_clr = (ack_second && use_slave_ff && !s_dflt)
               ? 8'(1 << s_line) : 8'h00;

  irq_sense_bank #(.N(LINES_PER_BANK), .PER_LINE(PER_LINE)) u_master
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .irq_in({irq_in[7:3], irq_in[2] | s_req, irq_in[1:0]}),
    .line_trig(master_trig_ff),
    .bank_trig(master_bank_trig_ff),
    .ack_first(ack_first),
    .ack_second(ack_second && !use_slave_ff),
    .end_cmd(m_end),
    .end_line(m_line),
    .req_clear(m_clr),
    .req_any(m_req),
    .ack_line(m_line),
    .ack_default(m_dflt),
    .in_service_bits(m_insvc)
  );

  irq_sense_bank #(.N(LINES_PER_BANK), .PER_LINE(PER_LINE)) u_slave
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .irq_in(irq_in[15:8]),
    .line_trig(slave_trig_ff),
    .bank_trig(slave_bank_trig_ff),
    .ack_first(ack_first),
    .ack_second(ack_second && use_slave_ff),
    .end_cmd(s_end),
    .end_line(s_line),
    .req_clear(s_clr),
    .req_any(s_req),
    .ack_line(s_line),
    .ack_default(s_dflt),
    .in_service_bits(s_insvc)
  );

  // ************************************************************
  // interrupt request and vector
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      intr_ff <= 1'b0;
    else
      intr_ff <= m_req && ack_ff == ACK_IDLE;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      vector_ff <= 8'h00;
      vector_valid_ff <= 1'b0;
    end
    else
    begin
      vector_valid_ff <= ack_second;
      if (ack_second)
        vector_ff <= use_slave_ff ? (SLAVE_VEC_BASE | {5'h00, s_line})
                                  : (MASTER_VEC_BASE | {5'h00, m_line});
    end
  end

  // ************************************************************
  // nmi sources, enables and mask
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      nmi_ctrl_ff <= RST_NMI_CTRL;
    else if (io_wr && io_addr == PORT_NMI_STATUS)
      nmi_ctrl_ff <= io_wdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      nmi_mask_ff <= RST_NMI_MASK;
    else if (io_wr && io_addr == PORT_NMI_MASK)
      nmi_mask_ff <= io_wdata[NMI_MASK_BIT];
  end

  // an enable bit of 1 disables and clears; a new cause wins otherwise
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      chk_det_ff <= 1'b0;
    else if (nmi_ctrl_ff[NMI_CHK_EN_BIT])
      chk_det_ff <= 1'b0;
    else if (!chan_chk_n)
      chk_det_ff <= 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      serr_det_ff <= 1'b0;
    else if (nmi_ctrl_ff[NMI_SERR_EN_BIT])
      serr_det_ff <= 1'b0;
    else if (!sys_err_n)
      serr_det_ff <= 1'b1;
  end

  // mask gates the output only; detectors keep their state
  assign nmi_nxt = (chk_det_ff || serr_det_ff) && !nmi_mask_ff;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      nmi_ff <= 1'b0;
    else
      nmi_ff <= nmi_nxt;
  end

  // ************************************************************
  // read path, one cycle after the read strobe
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      io_rdata_ff <= 8'h00;
      io_rvalid_ff <= 1'b0;
    end
    else
    begin
      io_rvalid_ff <= io_rd;
      if (io_rd)
        case (io_addr)
          PORT_NMI_STATUS:
            io_rdata_ff <= {serr_det_ff, chk_det_ff, 2'b00,
                            nmi_ctrl_ff[3:0]};
          PORT_NMI_MASK:
            io_rdata_ff <= {nmi_mask_ff, 7'h00};
          PORT_MASTER_TRIG:
            io_rdata_ff <= PER_LINE ? master_trig_ff : 8'h00;
          PORT_SLAVE_TRIG:
            io_rdata_ff <= PER_LINE ? slave_trig_ff : 8'h00;
          PORT_MASTER_CTRL:
            io_rdata_ff <= m_insvc;
          PORT_SLAVE_CTRL:
            io_rdata_ff <= s_insvc;
          default:
            io_rdata_ff <= 8'h00;
        endcase
    end
  end

  assign io_rdata = io_rdata_ff;
  assign io_rvalid = io_rvalid_ff;
  assign intr_out = intr_ff;
  assign vector_out = vector_ff;
  assign vector_valid = vector_valid_ff;
  assign nmi_out = nmi_ff;
endmodule

// ==== design/irq_sense_bank.sv ====
`timescale 1ns/1ps
// one bank of request sensing: edge or level per line, request latch,
// in-service bits, resolution at the first acknowledge
module irq_sense_bank
  import irq_nmi_pkg::*;
#(
  parameter int N = 8,
  parameter bit PER_LINE = 1'b1
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request pins and trigger selects
  input wire logic [N-1:0] irq_in,
  input wire logic [N-1:0] line_trig,
  input wire logic bank_trig,
  // acknowledge sequencing from the top
  input wire logic ack_first,
  input wire logic ack_second,
  input wire logic end_cmd,
  input wire logic [2:0] end_line,
  input wire logic [N-1:0] req_clear,
  // results
  output logic req_any,
  output logic [2:0] ack_line,
  output logic ack_default,
  output logic [N-1:0] in_service_bits
);
  logic [N-1:0] prev_ff;
  logic [N-1:0] pend_ff;
  logic [N-1:0] insvc_ff;
  logic [N-1:0] active;
  logic [N-1:0] level_mode;
  logic [N-1:0] raw_req;
  logic [2:0] sel_ff;
  logic dflt_ff;

  // ************************************************************
  // per-line sensing
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_line
      // per-line mode ignores the bank bit; per-line level lines are active low, bank level lines active high
      assign level_mode[g] = PER_LINE ? line_trig[g] : bank_trig;
      assign active[g] = (PER_LINE && line_trig[g]) ? !irq_in[g]
                                                    : irq_in[g];
      assign raw_req[g] = level_mode[g] ? active[g]
                        : (irq_in[g] && !prev_ff[g]);

      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          prev_ff[g] <= 1'b0;
        else
          prev_ff[g] <= irq_in[g];
      end

      // edge latch holds until taken or the input falls; level only while the input stays
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
          pend_ff[g] <= 1'b0;
        else if (raw_req[g])
          pend_ff[g] <= 1'b1;
        else if (level_mode[g] || req_clear[g] || !active[g])
          pend_ff[g] <= 1'b0;
      end
    end
  endgenerate

  // ************************************************************
  // resolution: lowest pending line wins, none gives default line
  // ************************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sel_ff <= 3'h0;
      dflt_ff <= 1'b0;
    end
    else if (ack_first)
    begin
      sel_ff <= 3'(DEFAULT_LINE);
      dflt_ff <= 1'b1;
      for (int i = N - 1; i >= 0; i--)
        if (pend_ff[i])
        begin
          sel_ff <= 3'(i);
          dflt_ff <= 1'b0;
        end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      insvc_ff <= '0;
    else
    begin
      // a default answer leaves the in-service bit alone
      if (ack_second && !dflt_ff)
        insvc_ff[sel_ff] <= 1'b1;
      if (end_cmd && !(ack_second && !dflt_ff && sel_ff == end_line))
        insvc_ff[end_line] <= 1'b0;
    end
  end

  assign req_any = |pend_ff;
  assign ack_line = sel_ff;
  assign ack_default = dflt_ff;
  assign in_service_bits = insvc_ff;
endmodule

// ==== inc/irq_nmi_pkg.sv ====
package irq_nmi_pkg;

  // ************************************************************
  // i/o port map
  // ************************************************************
  localparam logic [15:0] PORT_NMI_STATUS = 16'h0061;
  localparam logic [15:0] PORT_NMI_MASK = 16'h0070;
  localparam logic [15:0] PORT_MASTER_CTRL = 16'h0020;
  localparam logic [15:0] PORT_SLAVE_CTRL = 16'h00a0;
  localparam logic [15:0] PORT_MASTER_TRIG = 16'h04d0;
  localparam logic [15:0] PORT_SLAVE_TRIG = 16'h04d1;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int INIT_WORD_BIT = 4;
  localparam int BANK_TRIG_BIT = 3;
  localparam int END_BIT = 5;
  localparam int NMI_CHK_STAT_BIT = 6;
  localparam int NMI_SERR_STAT_BIT = 7;
  localparam int NMI_CHK_EN_BIT = 3;
  localparam int NMI_SERR_EN_BIT = 2;
  localparam int NMI_MASK_BIT = 7;
  localparam int LINES_PER_BANK = 8;
  localparam int DEFAULT_LINE = 7;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_NMI_CTRL = 8'h0c;
  localparam logic RST_NMI_MASK = 1'b1;
  localparam logic RST_BANK_TRIG = 1'b0;

  // ************************************************************
  // acknowledge sequence
  // ************************************************************
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_FIRST = 2'b01,
    ACK_GAP = 2'b10,
    ACK_SECOND = 2'b11
  } ack_state_e;

endpackage
